// [verilog/tmr_pkg.sv]
package tmr_pkg;

   // register offsets (byte addresses)
   localparam logic [3:0] REG_COUNT = 4'h0;
   localparam logic [3:0] REG_MODE  = 4'h4;
   localparam logic [3:0] REG_CTRL  = 4'h8;
   localparam logic [3:0] REG_STAT  = 4'hC;

   // channel_mode_reg fields
   localparam int MD_ONESHOT  = 0;
   localparam int MD_FREERUN  = 1;
   localparam int MD_PULSE    = 2;
   localparam int MD_QUAD4    = 3;
   localparam int MD_TRIGEDGE = 4;
   localparam int MD_SRC_LO   = 5;

   // control fields
   localparam int CT_RUN      = 0;
   localparam int CT_SOFT     = 1;
   localparam int CT_IDXEN    = 2;
   localparam int CT_TWOPH    = 3;
   localparam int CT_TSEL_LO  = 4;
   localparam int CT_IRQ2POL  = 6;

   localparam logic [2:0] SRC_F1   = 3'h0;
   localparam logic [2:0] SRC_F2   = 3'h1;
   localparam logic [2:0] SRC_F8   = 3'h2;
   localparam logic [2:0] SRC_F32  = 3'h3;
   localparam logic [2:0] SRC_SUBCLOCK_DIV32 = 3'h4;

   localparam logic [1:0] TSEL_PIN  = 2'h0;
   localparam logic [1:0] TSEL_TB2  = 2'h1;
   localparam logic [1:0] TSEL_PREV = 2'h2;
   localparam logic [1:0] TSEL_NEXT = 2'h3;

   localparam logic [7:0]  MODE_RST     = 8'h00;
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [15:0] CNT_RST      = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [15:0] ONESHOT_READ = 16'h0000;

   typedef enum logic [2:0] {
      ST_STOP  = 3'b001,
      ST_WAIT  = 3'b010,
      ST_COUNT = 3'b100
   } os_state_e;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   typedef struct packed {
      logic tb2;
      logic prev;
      logic next;
   } ovf_in_s;

   typedef struct packed {
      os_state_e   st;
      logic [15:0] cnt;
      logic [15:0] reload;
      logic [7:0]  mode;
      logic [7:0]  ctrl;
      logic [4:0]  pre;
      logic        a_old;
      logic        b_old;
      logic        z_old;
      logic        idx_pend;
      logic        first;
      logic        irq;
      logic        irq_again;
      logic        ovf;
      logic [15:0] rdata;
   } tmr_state_s;

endpackage

// [verilog/timer_channel.sv]
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ns
// Function
// - quad select valid only on channel three
// - index clear: channel three, free-run, x4
// - index edge direction from irq2 polarity
// - index clears counter at next count
// - coincident wrap and clear: two requests
// - one-shot counts down, reloads, stops
// - retrigger while counting reloads and restarts
// - n periods active; zero reload inactive
// - one-shot starts on run plus trigger
// - pin, second-family, neighbour wrap triggers
// - software start bit acts as trigger
// - clearing run bit stops counter
// - request raised when counter reaches zero
// - counter read in one-shot undefined
// - early write loads reload and counter
// - later write loads reload only
// - pulse output high only while counting
// - pins: trigger input, pulse output
// - x4 counts all edges, phase sets direction
// - free-run wraps without reload
module timer_channel
   import tmr_pkg::*;
#(
   parameter int CHAN = 3
)(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire reg_req_s    reg_req,
   output logic [15:0]      rdata,
   input  wire logic        timer_input_pin,
   input  wire logic        timer_output_pin_i,
   output logic             timer_output_pin_o,
   output logic             timer_output_pin_oe,
   input  wire logic        ext_irq2_pin,
   input  wire logic        subclock_div32,
   input  wire ovf_in_s     ovf_in,
   output logic             irq_req,
   output logic             ovf_out
);

   tmr_state_s s_ff;
   tmr_state_s nxt_s;

   logic os_mode;
   logic run;
   logic two_phase_enable;
   logic quad4;
   logic src_tick;
   logic a_edge;
   logic b_edge;
   logic ev;
   logic up;
   logic wrap;
   logic idx_mode;
   logic z_edge;
   logic pin_trig;
   logic hw_trig;
   logic soft_one_shot_start;
   logic trig;
   logic wr_cnt;

   assign os_mode          = s_ff.mode[MD_ONESHOT];
   assign run              = s_ff.ctrl[CT_RUN];
   assign two_phase_enable = s_ff.ctrl[CT_TWOPH];

   // channel two fixed normal, four fixed x4
   assign quad4 = (CHAN == 4) || ((CHAN == 3) && s_ff.mode[MD_QUAD4]);

   always_comb begin
      case (s_ff.mode[MD_SRC_LO +: 3])
         SRC_F1:   src_tick = 1'b1;
         SRC_F2:   src_tick = s_ff.pre[0];
         SRC_F8:   src_tick = &s_ff.pre[2:0];
         SRC_F32:  src_tick = &s_ff.pre;
         SRC_SUBCLOCK_DIV32: src_tick = subclock_div32;
         default:  src_tick = 1'b0;
      endcase
   end

   // phase a on the input pin, phase b on the output pin
   assign a_edge = timer_input_pin ^ s_ff.a_old;
   assign b_edge = timer_output_pin_i ^ s_ff.b_old;

   // in x4, both phases moving at once is a glitch, not a count
   assign ev = two_phase_enable &&
               (quad4 ? (a_edge ^ b_edge)
                      : (a_edge && timer_output_pin_i));
   assign up = quad4 ? (timer_output_pin_i ^ s_ff.a_old)
                     : timer_input_pin;
   assign wrap = up ? (s_ff.cnt == CNT_MAX) : (s_ff.cnt == CNT_RST);

   assign idx_mode = (CHAN == 3) && !os_mode && two_phase_enable &&
                     s_ff.mode[MD_FREERUN] && quad4 &&
                     s_ff.ctrl[CT_IDXEN];
   assign z_edge = s_ff.ctrl[CT_IRQ2POL] ?
                   (ext_irq2_pin && !s_ff.z_old) :
                   (!ext_irq2_pin && s_ff.z_old);

   assign pin_trig = s_ff.mode[MD_TRIGEDGE] ?
                     (!timer_input_pin && s_ff.a_old) :
                     (timer_input_pin && !s_ff.a_old);

   always_comb begin
      case (s_ff.ctrl[CT_TSEL_LO +: 2])
         TSEL_PIN:  hw_trig = pin_trig;
         TSEL_TB2:  hw_trig = ovf_in.tb2;
         TSEL_PREV: hw_trig = ovf_in.prev;
         TSEL_NEXT: hw_trig = ovf_in.next;
         default:   hw_trig = 1'b0;
      endcase
   end

   assign wr_cnt = reg_req.wr && (reg_req.addr == REG_COUNT);
   assign soft_one_shot_start = reg_req.wr && (reg_req.addr == REG_CTRL) &&
                                reg_req.wdata[CT_SOFT];
   // triggers count only while the run bit already stands
   assign trig = run && (hw_trig || soft_one_shot_start);

   always_comb begin
      nxt_s           = s_ff;
      nxt_s.pre       = s_ff.pre + 5'h01;
      nxt_s.a_old     = timer_input_pin;
      nxt_s.b_old     = timer_output_pin_i;
      nxt_s.z_old     = ext_irq2_pin;
      nxt_s.irq       = s_ff.irq_again;
      nxt_s.irq_again = 1'b0;
      nxt_s.ovf       = 1'b0;
      nxt_s.rdata     = 16'h0000;

      if (!os_mode) begin
         nxt_s.st = ST_STOP;
         if (run && ev) begin
            nxt_s.first = 1'b1;
            if (s_ff.idx_pend) begin
               nxt_s.cnt = CNT_RST;
            end else if (wrap && !s_ff.mode[MD_FREERUN]) begin
               nxt_s.cnt = s_ff.reload;
            end else begin
               // free-run wraps through the adder
               nxt_s.cnt = up ? s_ff.cnt + 16'h0001
                              : s_ff.cnt - 16'h0001;
            end
            if (wrap) begin
               nxt_s.irq       = 1'b1;
               nxt_s.ovf       = 1'b1;
               nxt_s.irq_again = s_ff.idx_pend;
            end
            nxt_s.idx_pend = 1'b0;
         end
         // an edge in the clearing cycle stays pending
         if (idx_mode && z_edge) begin
            nxt_s.idx_pend = 1'b1;
         end
         if (!idx_mode) begin
            nxt_s.idx_pend = 1'b0;
         end
      end else begin
         nxt_s.idx_pend = 1'b0;
         case (s_ff.st)
            ST_STOP: begin
               if (run) begin
                  nxt_s.st = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (trig && (s_ff.reload != CNT_RST)) begin
                  nxt_s.st  = ST_COUNT;
                  nxt_s.cnt = s_ff.reload;
               end
            end
            ST_COUNT: begin
               if (trig) begin
                  nxt_s.cnt = s_ff.reload;
               end else if (src_tick) begin
                  nxt_s.first = 1'b1;
                  if (s_ff.cnt <= 16'h0001) begin
                     nxt_s.cnt = s_ff.reload;
                     nxt_s.st  = ST_WAIT;
                     nxt_s.irq = 1'b1;
                     nxt_s.ovf = 1'b1;
                  end else begin
                     nxt_s.cnt = s_ff.cnt - 16'h0001;
                  end
               end
            end
            default: begin
               nxt_s.st = ST_STOP;
            end
         endcase
      end

      if (!run) begin
         nxt_s.st    = ST_STOP;
         nxt_s.first = 1'b0;
      end

      if (wr_cnt) begin
         nxt_s.reload = reg_req.wdata;
         if (!run || !s_ff.first) begin
            nxt_s.cnt = reg_req.wdata;
         end
      end
      if (reg_req.wr && (reg_req.addr == REG_MODE)) begin
         nxt_s.mode = reg_req.wdata[7:0];
      end
      if (reg_req.wr && (reg_req.addr == REG_CTRL)) begin
         // start bit is a strobe and never stored
         nxt_s.ctrl          = reg_req.wdata[7:0];
         nxt_s.ctrl[CT_SOFT] = 1'b0;
      end

      if (reg_req.rd) begin
         case (reg_req.addr)
            REG_COUNT: nxt_s.rdata = os_mode ? ONESHOT_READ : s_ff.cnt;
            REG_MODE:  nxt_s.rdata = {8'h00, s_ff.mode};
            REG_CTRL:  nxt_s.rdata = {8'h00, s_ff.ctrl};
            REG_STAT:  nxt_s.rdata = {12'h000, s_ff.idx_pend,
                                      timer_output_pin_o, s_ff.first,
                                      (s_ff.st == ST_COUNT)};
            default:   nxt_s.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_ff           <= '0;
         s_ff.st        <= ST_STOP;
         s_ff.cnt       <= CNT_RST;
         s_ff.reload    <= CNT_RST;
         s_ff.mode      <= MODE_RST;
         s_ff.ctrl      <= CTRL_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign rdata   = s_ff.rdata;
   assign irq_req = s_ff.irq;
   assign ovf_out = s_ff.ovf;
   assign timer_output_pin_o  = (s_ff.st == ST_COUNT);
   // pin stays an input while used as phase b
   assign timer_output_pin_oe = os_mode && s_ff.mode[MD_PULSE] &&
                                !two_phase_enable;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence os_last_tick;
      os_mode && run && (s_ff.st == ST_COUNT) && !trig && src_tick &&
      (s_ff.cnt == 16'h0001) && !wr_cnt;
   endsequence

   sequence idx_clear_wrap;
      !os_mode && run && ev && s_ff.idx_pend && wrap;
   endsequence

   AST_STOP_ON_RUN: assert property (
      !run |=> (s_ff.st == ST_STOP) && !timer_output_pin_o)
      else $error("counter kept running with run bit clear");

   AST_LAST_TICK: assert property (
      os_last_tick |=> irq_req && (s_ff.st == ST_WAIT) &&
                       (s_ff.cnt == $past(s_ff.reload)))
      else $error("one-shot end did not reload and stop");

   AST_END_IRQ: assert property (
      os_mode && $rose(irq_req) |-> $past(s_ff.st == ST_COUNT))
      else $error("one-shot request without a running count");

   AST_RETRIG: assert property (
      os_mode && run && (s_ff.st == ST_COUNT) && trig && !wr_cnt
      |=> (s_ff.st == ST_COUNT) && (s_ff.cnt == $past(s_ff.reload)))
      else $error("retrigger did not reload");

   AST_ZERO_IDLE: assert property (
      os_mode && (s_ff.st == ST_WAIT) && (s_ff.reload == CNT_RST)
      |=> (s_ff.st != ST_COUNT))
      else $error("zero reload started the counter");

   AST_NEED_TRIG: assert property (
      (s_ff.st == ST_WAIT) && !trig |=> (s_ff.st != ST_COUNT))
      else $error("count began without a trigger");

   AST_SOFT_START: assert property (
      os_mode && run && (s_ff.st == ST_WAIT) && soft_one_shot_start &&
      (s_ff.reload != CNT_RST) && !wr_cnt
      |=> (s_ff.st == ST_COUNT) && timer_output_pin_o)
      else $error("software start ignored");

   AST_EARLY_WRITE: assert property (
      wr_cnt && !s_ff.first && (!run || !os_mode || (s_ff.st != ST_COUNT))
      && !(run && ev && !os_mode)
      |=> (s_ff.cnt == $past(reg_req.wdata)) &&
          (s_ff.reload == $past(reg_req.wdata)))
      else $error("early write missed the counter");

   AST_LATE_WRITE: assert property (
      wr_cnt && run && s_ff.first && os_mode && (s_ff.st == ST_WAIT) && !trig
      |=> (s_ff.cnt == $past(s_ff.cnt)) &&
          (s_ff.reload == $past(reg_req.wdata)))
      else $error("late write reached the counter");

   AST_IDX_CLEAR: assert property (
      !os_mode && run && ev && s_ff.idx_pend && !wr_cnt
      |=> (s_ff.cnt == CNT_RST))
      else $error("index clear missed the count");

   AST_IDX_ONLY: assert property (
      !idx_mode |=> !$rose(s_ff.idx_pend))
      else $error("index pending outside its mode");

   AST_DOUBLE_IRQ: assert property (
      idx_clear_wrap |=> irq_req ##1 irq_req)
      else $error("coincident wrap gave no second request");

   AST_FREERUN: assert property (
      !os_mode && run && ev && !s_ff.idx_pend && wrap &&
      s_ff.mode[MD_FREERUN] && !wr_cnt
      |=> (s_ff.cnt == ($past(up) ? CNT_RST : CNT_MAX)))
      else $error("free-run wrap loaded the reload value");

endmodule // timer_channel

// [testbench/enc_src.sv]
`timescale 1ns/1ns
module enc_src
   import tmr_pkg::*;
(
   input  wire logic mclk,
   output logic      phase_a,
   output logic      phase_b,
   output logic      index_z,
   output logic      sub_tick,
   output ovf_in_s   ovf
);
   logic [1:0] q_ff;
   logic       trg_ff;
   initial begin
      q_ff = 2'h0;
      trg_ff = 1'b0;
      index_z = 1'b0;
      sub_tick = 1'b0;
      ovf = '0;
   end
   // gray walk: stepping up, b leads a
   assign phase_a = q_ff[1] | trg_ff;
   assign phase_b = q_ff[1] ^ q_ff[0];
   task step(input logic up);
      @(posedge mclk);
      q_ff <= up ? q_ff + 2'h1 : q_ff - 2'h1;
      repeat (2) @(posedge mclk);
   endtask
   // k 0: pin level pulse; k 1..3: wrap pulse of tb2, prev, next
   task fire(input int k);
      @(posedge mclk);
      if (k == 0) trg_ff <= 1'b1;
      else ovf <= ovf_in_s'(3'h4 >> (k - 1));
      @(posedge mclk);
      ovf <= '0;
      repeat (2) @(posedge mclk);
      trg_ff <= 1'b0;
   endtask
   // held three cycles, as long as one encoder step period
   task pulse_z;
      @(posedge mclk);
      index_z <= 1'b1;
      repeat (3) @(posedge mclk);
      index_z <= 1'b0;
   endtask
   task sub_pulse;
      @(posedge mclk);
      sub_tick <= 1'b1;
      @(posedge mclk);
      sub_tick <= 1'b0;
   endtask
endmodule // enc_src

// [testbench/timer_oneshot_and_encoder_reset_tb_top.sv]
`timescale 1ns/1ns
module timer_oneshot_and_encoder_reset_tb_top
   import tmr_pkg::*;
;
   logic        mclk;
   logic        reset_n;
   reg_req_s    req;
   logic [15:0] rdata;
   logic        pout;
   logic        poe;
   logic        irq_req;
   logic        ovf_o;
   logic        pa;
   logic        pb;
   logic        pz;
   logic        sub;
   ovf_in_s     ovf;
   int          bad_count;
   int          n_tests;
   int          irqs;
   int          ovfs;
   int          len;
   int          ni;
   logic [15:0] v;

   timer_channel i_timer_channel (
      .mclk(mclk), .reset_n(reset_n), .reg_req(req), .rdata(rdata),
      .timer_input_pin(pa), .timer_output_pin_i(poe ? pout : pb),
      .timer_output_pin_o(pout), .timer_output_pin_oe(poe), .ext_irq2_pin(pz),
      .subclock_div32(sub), .ovf_in(ovf), .irq_req(irq_req), .ovf_out(ovf_o)
   );
   enc_src i_enc_src (
      .mclk(mclk), .phase_a(pa), .phase_b(pb), .index_z(pz), .sub_tick(sub), .ovf(ovf)
   );

   always #4 mclk = ~mclk;
   always @(negedge mclk) if (irq_req === 1'b1) irqs++;
   always @(negedge mclk) if (ovf_o === 1'b1) ovfs++;

   task wrap_up;
      if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   // length of the next output pulse and requests raised around it
   task meas(output int l, output int n);
      int w;
      int b;
      l = 0;
      w = 0;
      b = irqs;
      while (pout !== 1'b1 && w < 60) begin
         @(negedge mclk);
         w++;
      end
      while (pout === 1'b1 && l < 5000) begin
         @(negedge mclk);
         l++;
      end
      repeat (3) @(negedge mclk);
      n = irqs - b;
   endtask
   task arm(input logic [15:0] n, input logic [7:0] md, input logic [7:0] ct);
      wr(REG_CTRL, 16'h0000);
      wr(REG_COUNT, n);
      wr(REG_MODE, {8'h00, md});
      wr(REG_CTRL, {8'h00, ct});
   endtask

   task t_reset;
      rd(REG_MODE, v);
      chk("mode", v, 16'h0000);
      rd(REG_CTRL, v);
      chk("ctrl", v, 16'h0000);
   endtask
   task t_oneshot;
      arm(16'h0003, 8'h05, 8'h01);
      fork meas(len, ni); wr(REG_CTRL, 16'h0003); join
      chk("width", 16'(len), 16'h0003);
      chk("irq", 16'(ni), 16'h0001);
      chk("oe", {15'h0, poe}, 16'h0001);
      rd(REG_COUNT, v);
      chk("os_read", v, ONESHOT_READ);
   endtask
   task t_gate;
      arm(16'h0005, 8'h05, 8'h00);
      fork meas(len, ni); wr(REG_CTRL, 16'h0002); join
      chk("no_run", 16'(len), 16'h0000);
      arm(16'h0000, 8'h05, 8'h01);
      fork meas(len, ni); wr(REG_CTRL, 16'h0003); join
      chk("zero", 16'(len), 16'h0000);
      arm(16'h0064, 8'h05, 8'h01);
      wr(REG_CTRL, 16'h0003);
      repeat (10) @(posedge mclk);
      ni = irqs;
      wr(REG_CTRL, 16'h0000);
      repeat (3) @(negedge mclk);
      chk("stop", {15'h0, pout}, 16'h0000);
      chk("stop_irq", 16'(irqs - ni), 16'h0000);
   endtask
   task t_triggers;
      for (int k = 0; k < 5; k++) begin
         arm(16'h0006, k == 4 ? 8'h15 : 8'h05, 8'h01 | 8'((k % 4) << 4));
         fork meas(len, ni); i_enc_src.fire(k % 4); join
         chk("trig", 16'(len), 16'h0006);
      end
   endtask
   task t_retrig;
      arm(16'h000A, 8'h05, 8'h11);
      fork
         meas(len, ni);
         begin
            i_enc_src.fire(1);
            repeat (4) @(posedge mclk);
            i_enc_src.fire(1);
         end
      join
      chk("retrig", {15'h0, len > 10}, 16'h0001);
      chk("retrig_irq", 16'(ni), 16'h0001);
   endtask
   task t_reload;
      arm(16'h0014, 8'h05, 8'h01);
      fork
         meas(len, ni);
         begin
            wr(REG_CTRL, 16'h0003);
            repeat (5) @(posedge mclk);
            wr(REG_COUNT, 16'h0004);
         end
      join
      chk("old_n", 16'(len), 16'h0014);
      fork meas(len, ni); wr(REG_CTRL, 16'h0003); join
      chk("new_n", 16'(len), 16'h0004);
      // write while idle after a finished count reaches the reload only
      wr(REG_COUNT, 16'h0007);
      fork meas(len, ni); wr(REG_CTRL, 16'h0003); join
      chk("wait_n", 16'(len), 16'h0007);
   endtask
   task t_subclk;
      arm(16'h0002, 8'h85, 8'h01);
      wr(REG_CTRL, 16'h0003);
      ni = irqs;
      repeat (2) begin
         repeat (6) @(negedge mclk);
         chk("sub_hi", {15'h0, pout}, 16'h0001);
         i_enc_src.sub_pulse;
      end
      repeat (6) @(negedge mclk);
      chk("sub_lo", {15'h0, pout}, 16'h0000);
      chk("sub_irq", 16'(irqs - ni), 16'h0001);
   endtask
   task t_quad;
      arm(16'h0005, 8'h0A, 8'h00);
      rd(REG_COUNT, v);
      chk("pre_load", v, 16'h0005);
      wr(REG_CTRL, 16'h0009);
      repeat (5) i_enc_src.step(1'b1);
      rd(REG_COUNT, v);
      chk("up", v, 16'h000A);
      ni = irqs;
      repeat (12) i_enc_src.step(1'b0);
      rd(REG_COUNT, v);
      chk("down", v, 16'hFFFE);
      chk("wrap_irq", 16'(irqs - ni), 16'h0001);
      wr(REG_COUNT, 16'h0000);
      wr(REG_CTRL, 16'h004D);
      rd(REG_COUNT, v);
      chk("reload_only", v, 16'hFFFE);
      i_enc_src.pulse_z;
      rd(REG_COUNT, v);
      chk("z_wait", v, 16'hFFFE);
      i_enc_src.step(1'b1);
      rd(REG_COUNT, v);
      chk("z_clear", v, 16'h0000);
      i_enc_src.step(1'b1);
      rd(REG_COUNT, v);
      chk("after", v, 16'h0001);
      i_enc_src.step(1'b0);
      i_enc_src.pulse_z;
      rd(REG_STAT, v);
      chk("stat", v, 16'h000A);
      ni = irqs;
      len = ovfs;
      // clear lands on an underflow: request twice, one wrap pulse
      i_enc_src.step(1'b0);
      rd(REG_COUNT, v);
      chk("dbl_cnt", v, 16'h0000);
      chk("dbl_irq", 16'(irqs - ni), 16'h0002);
      chk("dbl_ovf", 16'(ovfs - len), 16'h0001);
      wr(REG_MODE, 16'h0002);
      repeat (4) i_enc_src.step(1'b1);
      rd(REG_COUNT, v);
      chk("normal", v, 16'h0001);
   endtask

   // run takes under a thousand cycles; thirty times that is a hang
   initial begin
      #(30000 * 8);
      bad_count++;
      wrap_up;
   end
   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      req = '0;
      bad_count = 0;
      n_tests = 0;
      irqs = 0;
      ovfs = 0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      t_reset;
      t_oneshot;
      t_gate;
      t_triggers;
      t_retrig;
      t_reload;
      t_subclk;
      t_quad;
      wrap_up;
   end
endmodule // timer_oneshot_and_encoder_reset_tb_top
